//--- common/tpc_map.vh
// Register map, field positions, codes and reset values of the timer pulse block.
`ifndef TPC_MAP_VH
`define TPC_MAP_VH

// Channel count.
`define TPC_NUM_CH        2

// Register byte addresses.
`define TPC_ADDR_TSC      12'h000
`define TPC_ADDR_CNTH     12'h004
`define TPC_ADDR_CNTL     12'h008
`define TPC_ADDR_MODH     12'h00C
`define TPC_ADDR_MODL     12'h010
// Channel n occupies 0x020 + 0x010*n; word index within the channel block.
`define TPC_CH_BASE_IDX   4'h2
`define TPC_CH_SUB_SC     2'h0
`define TPC_CH_SUB_VH     2'h1
`define TPC_CH_SUB_VL     2'h2

// Timer status/control fields.
`define TPC_TSC_OVF       7
`define TPC_TSC_OVIE      6
`define TPC_TSC_CPWM      5
`define TPC_TSC_CLKS_HI   4
`define TPC_TSC_CLKS_LO   3

// Channel status/control fields.
`define TPC_CSC_FLAG      7
`define TPC_CSC_IE        6
`define TPC_CSC_MODE_HI   5
`define TPC_CSC_MODE_LO   4
`define TPC_CSC_ELS_HI    3
`define TPC_CSC_ELS_LO    2

// Clock source codes.
`define TPC_CLK_OFF       2'h0
`define TPC_CLK_BUS       2'h1
`define TPC_CLK_FIXED     2'h2
`define TPC_CLK_EXT       2'h3

// Edge/level codes.
`define TPC_ELS_OFF       2'h0
`define TPC_ELS_01        2'h1
`define TPC_ELS_10        2'h2
`define TPC_ELS_11        2'h3

// Channel mode codes.
`define TPC_MODE_CAP      2'h0
`define TPC_MODE_CMP      2'h1
`define TPC_MODE_EPWM     2'h2
`define TPC_MODE_CPWM     2'h3

// Reset values.
`define TPC_TSC_RST       4'h0
`define TPC_CSC_RST       5'h00
`define TPC_VAL_RST       16'h0000
`define TPC_MOD_RST       16'h0000
`define TPC_CNT_RST       16'h0000
`define TPC_TERM_FREE     16'hFFFF

`endif

//--- test/tb_top.sv
// Self-checking bench for the timer pulse block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        clock = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        fixed_clk_tick = 1'b0;
  logic        debug_active = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [1:0]  pin_req = 2'h0;
  logic [7:0]  d;
  logic        e;
  wire         pready, pslverr, ovf_irq, ext_clk_in;
  wire  [31:0] prdata;
  wire  [1:0]  ch_pin_in, ch_pin_out, ch_pin_oe, ch_irq;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          h;

  tpc_timer uut (.*);
  tpc_pin_partner pp (.clock(clock), .pin_req(pin_req), .pin(ch_pin_in), .ext_clk(ext_clk_in));

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cyc <= cyc + 1;
    fixed_clk_tick <= (cyc % 8 == 7);
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, x);
    end
  endtask

  // One bus transfer; read data and error are kept in d and e.
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, v};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    d = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  task automatic start(input logic [7:0] t, input logic [15:0] m, input logic [7:0] c, input logic [15:0] v);
    bus(1'b1, 12'h000, 8'h00);
    bus(1'b1, 12'h004, 8'h00);
    bus(1'b1, 12'h00C, m[15:8]);
    bus(1'b1, 12'h010, m[7:0]);
    bus(1'b1, 12'h020, c);
    bus(1'b1, 12'h024, v[15:8]);
    bus(1'b1, 12'h028, v[7:0]);
    bus(1'b1, 12'h000, t);
  endtask

  task automatic hcount(input int n);
    h = 0;
    repeat (n) begin
      @(posedge clock);
      h += (ch_pin_out[0] === 1'b1);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    bus(1'b0, 12'h000, 8'h00);
    chk(d, 8'h00);
    bus(1'b0, 12'h038, 8'h00);
    chk(d, 8'h00);
    bus(1'b0, 12'h02C, 8'h00);
    chk(e, 1'b1);
    bus(1'b1, 12'h024, 8'hA5);
    bus(1'b1, 12'h028, 8'h5A);
    bus(1'b0, 12'h024, 8'h00);
    chk(d, 8'hA5);
    bus(1'b0, 12'h028, 8'h00);
    chk(d, 8'h5A);
  endtask

  task automatic t_clocks;
    logic [1:0] code [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
    int         x [5] = '{83, 10, 21, 0, 0};
    for (int i = 0; i < 5; i++) begin
      debug_active <= (i == 3);
      start({3'h0, code[i], 3'h0}, 16'h0000, 8'h00, 16'h0000);
      repeat (80) @(posedge clock);
      bus(1'b1, 12'h000, 8'h00);
      bus(1'b0, 12'h008, 8'h00);
      chk({15'h0000, (d + 3 >= x[i]) && (d <= x[i] + ((x[i] == 0) ? 0 : 3))}, 16'h0001);
    end
    debug_active <= 1'b0;
  endtask

  task automatic t_coh;
    start(8'h08, 16'h0000, 8'h00, 16'h0000);
    bus(1'b0, 12'h004, 8'h00);
    chk(d, 8'h00);
    repeat (600) @(posedge clock);
    bus(1'b0, 12'h008, 8'h00);
    chk({15'h0000, d < 8'h10}, 16'h0001);
    bus(1'b0, 12'h004, 8'h00);
    chk(d, 8'h02);
    bus(1'b0, 12'h004, 8'h00);
    bus(1'b1, 12'h008, 8'h77);
    bus(1'b0, 12'h008, 8'h00);
    chk({15'h0000, d < 8'h08}, 16'h0001);
  endtask

  task automatic t_ovf;
    start(8'h48, 16'h0003, 8'h00, 16'h0000);
    repeat (10) @(posedge clock);
    chk(ovf_irq, 1'b1);
    bus(1'b0, 12'h008, 8'h00);
    chk({15'h0000, d <= 8'h03}, 16'h0001);
    bus(1'b1, 12'h000, 8'h40);
    bus(1'b0, 12'h000, 8'h00);
    chk(d, 8'hC0);
    bus(1'b1, 12'h000, 8'h40);
    chk(ovf_irq, 1'b0);
  endtask

  task automatic t_cmp;
    logic [1:0] els;
    for (int i = 3; i >= 0; i--) begin
      els = i[1:0];
      start(8'h08, 16'h0000, {4'h5, els, 2'h0}, 16'h0010);
      repeat (40) @(posedge clock);
      chk(ch_pin_oe[0], els != 2'h0);
      if (els != 2'h0) chk(ch_pin_out[0], els != 2'h2);
      chk(ch_irq[0], 1'b1);
      bus(1'b0, 12'h020, 8'h00);
      bus(1'b1, 12'h020, {4'h5, els, 2'h0});
      chk(ch_irq[0], 1'b0);
    end
  endtask

  task automatic t_pwm;
    for (int i = 1; i < 3; i++) begin
      start(8'h08, 16'h0009, {4'h2, i[1:0], 2'h0}, 16'h0002);
      repeat (15) @(posedge clock);
      hcount(20);
      chk(h[15:0], (i == 2) ? 16'h0006 : 16'h000E);
    end
    bus(1'b1, 12'h000, 8'h00);
    bus(1'b0, 12'h000, 8'h00);
    chk(d[7], 1'b1);
    start(8'h28, 16'h0008, 8'h08, 16'h0003);
    bus(1'b0, 12'h000, 8'h00);
    chk(d[7], 1'b0);
    repeat (40) @(posedge clock);
    hcount(32);
    chk(h[15:0], 16'h000C);
    bus(1'b0, 12'h000, 8'h00);
    chk(d[7], 1'b1);
  endtask

  task automatic t_cap;
    logic [1:0] els;
    start(8'h08, 16'h0000, 8'h00, 16'h0000);
    for (int i = 1; i < 4; i++) begin
      els = i[1:0];
      bus(1'b1, 12'h030, {4'h0, els, 2'h0});
      pin_req <= 2'h2;
      repeat (4) @(posedge clock);
      bus(1'b0, 12'h030, 8'h00);
      chk(d[7], els[0]);
      bus(1'b1, 12'h030, {4'h0, els, 2'h0});
      pin_req <= 2'h0;
      repeat (4) @(posedge clock);
      bus(1'b0, 12'h030, 8'h00);
      chk(d[7], els[1]);
    end
    chk(ch_pin_oe[1], 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    t_reset();
    t_clocks();
    t_coh();
    t_ovf();
    t_cmp();
    t_pwm();
    t_cap();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire

//--- test/tpc_pin_partner.sv
// Model of the pins and external clock that face the timer block.
`timescale 1ns/100ps
`default_nettype none
module tpc_pin_partner (
  // Clock and pin requests.
  input  wire logic       clock,
  input  wire logic [1:0] pin_req,
  // Toward the timer.
  output wire logic [1:0] pin,
  output wire logic       ext_clk
);
  logic [1:0] div = 2'h0;
  logic [1:0] pin_q = 2'h0;
  logic       ext_q = 1'b0;

  assign pin = pin_q;
  assign ext_clk = ext_q;
  // Pins move one clock after a request and then hold steady.
  always @(posedge clock) begin
    div <= div + 2'h1;
    ext_q <= div[1];
    pin_q <= pin_req;
  end
endmodule // tpc_pin_partner
`default_nettype wire

//--- test/tpc_timer_asserts.sv
// Port-level checker of the timer pulse block.
`timescale 1ns/100ps
`default_nettype none
module tpc_timer_chk (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        sys_rst,
  // Register bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  // Clocks, pins and requests.
  input wire logic        fixed_clk_tick,
  input wire logic        ext_clk_in,
  input wire logic        debug_active,
  input wire logic [1:0]  ch_pin_in,
  input wire logic [1:0]  ch_pin_out,
  input wire logic [1:0]  ch_pin_oe,
  input wire logic        ovf_irq,
  input wire logic [1:0]  ch_irq
);
  wire wr_any = psel && penable && pwrite;
  wire wr0    = wr_any && (paddr == 12'h020);

  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  reset_clear_a: assert property (@(posedge clock) disable iff (1'b0)
    sys_rst |=> (ch_pin_oe == 2'h0 && ch_irq == 2'h0 && !ovf_irq && prdata == 32'h00000000))
    else $error("outputs not cleared by reset");
  oe_release_a: assert property (wr0 && pwdata[3:2] == 2'h0 |=> !ch_pin_oe[0])
    else $error("pin kept by released channel");
  oe_drive_a: assert property (wr0 && pwdata[5:4] != 2'h0 && pwdata[3:2] != 2'h0 |=> ch_pin_oe[0])
    else $error("output channel not driving");
  pin_hold_a: assert property (!ch_pin_oe[0] && !wr0 |=> $stable(ch_pin_out[0]))
    else $error("undriven pin value moved");
  prdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
  ovf_fall_a: assert property ($fell(ovf_irq) |-> $past(wr_any) || $past(sys_rst))
    else $error("overflow request dropped alone");
  ch_fall_a: assert property (($past(ch_irq) & ~ch_irq) != 2'h0 |-> $past(wr_any) || $past(sys_rst))
    else $error("channel request dropped alone");
  idle_quiet_a: assert property (!(psel && penable) |-> !pslverr && pready)
    else $error("bus error outside access");
endmodule // tpc_timer_chk

bind tpc_timer tpc_timer_chk chk_i (.*);
`default_nettype wire

//--- verilog/tpc_timer.v
// Timer pulse module: counter, modulus and capture/compare/PWM channels behind an APB slave.
`timescale 1ns/100ps
`default_nettype none
`include "tpc_map.vh"

// Function
// - Edge/level code 00 releases the channel pin from timer use.
// - Capture mode takes rising, falling or either edge per edge/level code.
// - Compare mode: software only, toggle, clear or set pin on match.
// - Edge PWM: code 10 high-true pulses, code X1 low-true pulses.
// - Center PWM: compare while counting up ends the pulse, compare while counting down starts it.
// - Capture value read latches both bytes until other byte read; control write releases.
// - Compare/PWM value byte writes buffer; transfer after both bytes; control write resets.
// - Channel value bytes are read/write and cleared by reset.
// - Center select makes counter up/down and all channels center PWM.
// - Clock select resets to off; 01 bus clock, others fixed or external.
// - Counting pauses while debug is active.
// - Up counter runs zero to terminal count then wraps to zero.
// - Up/down counter turns at terminal count and zero, each end one tick long.
// - Overflow request is a level while flag and enable are set.
// - Up mode overflow flag sets on terminal count to zero step.
// - Up/down overflow flag sets on step down from terminal count.
// - Counter byte read captures both bytes until both are read.
// - Counter byte write clears the counter and its read coherency state.
// - Flag clears by read while set then write zero; new event wins.
// - Channel flag sets on capture edge or match; request while enabled.
// - Edge PWM value loads after both bytes and counter at zero.
module tpc_timer (
  // Clock and reset.
  input  wire                     clock,
  input  wire                     sys_rst,
  // APB slave.
  input  wire                     psel,
  input  wire                     penable,
  input  wire                     pwrite,
  input  wire [11:0]              paddr,
  input  wire [31:0]              pwdata,
  output wire                     pready,
  output wire                     pslverr,
  output reg  [31:0]              prdata,
  // Clock sources and system state.
  input  wire                     fixed_clk_tick,
  input  wire                     ext_clk_in,
  input  wire                     debug_active,
  // Channel pins.
  input  wire [`TPC_NUM_CH-1:0]   ch_pin_in,
  output wire [`TPC_NUM_CH-1:0]   ch_pin_out,
  output wire [`TPC_NUM_CH-1:0]   ch_pin_oe,
  // Interrupt requests.
  output wire                     ovf_irq,
  output wire [`TPC_NUM_CH-1:0]   ch_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode.

  wire        wr_acc   = psel & penable & pwrite;
  wire        rd_setup = psel & ~penable & ~pwrite;
  wire [3:0]  ch_idx   = paddr[7:4] - `TPC_CH_BASE_IDX;
  wire [1:0]  ch_sub   = paddr[3:2];
  wire        ch_hit   = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0) && (paddr[7:4] >= `TPC_CH_BASE_IDX) &&
                         (ch_idx < `TPC_NUM_CH) && (ch_sub != 2'h3);
  wire        top_hit  = (paddr == `TPC_ADDR_TSC) || (paddr == `TPC_ADDR_CNTH) || (paddr == `TPC_ADDR_CNTL) ||
                         (paddr == `TPC_ADDR_MODH) || (paddr == `TPC_ADDR_MODL);
  wire        wr_tsc   = wr_acc && (paddr == `TPC_ADDR_TSC);
  wire        wr_cnt   = wr_acc && ((paddr == `TPC_ADDR_CNTH) || (paddr == `TPC_ADDR_CNTL));
  wire        wr_modh  = wr_acc && (paddr == `TPC_ADDR_MODH);
  wire        wr_modl  = wr_acc && (paddr == `TPC_ADDR_MODL);
  wire        rd_tsc   = rd_setup && (paddr == `TPC_ADDR_TSC);
  wire        rd_cnth  = rd_setup && (paddr == `TPC_ADDR_CNTH);
  wire        rd_cntl  = rd_setup && (paddr == `TPC_ADDR_CNTL);

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~(ch_hit | top_hit);

  ////////////////////////////////////////////////////////////////////////////
  // Timer control and clock selection.

  reg  [3:0]  tsc_reg;
  reg         ovf_reg;
  reg         ovf_arm_reg;
  reg         ext_prev_reg;
  reg  [15:0] cnt_reg;
  reg         dir_up_reg;
  reg  [15:0] mod_reg;
  reg  [7:0]  mod_bh_reg;
  reg  [7:0]  mod_bl_reg;
  reg         mod_hw_reg;
  reg         mod_lw_reg;
  reg  [15:0] cnt_buf_reg;
  reg         cnt_lat_reg;
  reg         cnt_hrd_reg;
  reg         cnt_lrd_reg;

  wire        ovie     = tsc_reg[`TPC_TSC_OVIE-3];
  wire        cpwm     = tsc_reg[`TPC_TSC_CPWM-3];
  wire [1:0]  clks     = tsc_reg[`TPC_TSC_CLKS_HI-3:`TPC_TSC_CLKS_LO-3];
  wire        clk_on   = (clks != `TPC_CLK_OFF);
  wire        src_tick = (clks == `TPC_CLK_BUS) ||
                         ((clks == `TPC_CLK_FIXED) && fixed_clk_tick) ||
                         ((clks == `TPC_CLK_EXT) && ext_clk_in && ~ext_prev_reg);
  wire        tick     = src_tick & ~debug_active;

  ////////////////////////////////////////////////////////////////////////////
  // Main counter.

  wire [15:0] term     = (mod_reg == `TPC_MOD_RST) ? `TPC_TERM_FREE : mod_reg;
  wire        at_term  = (cnt_reg == term);
  wire        at_zero  = (cnt_reg == `TPC_CNT_RST);
  wire        up_wrap  = tick & ~cpwm & at_term;
  wire        turn_dn  = tick & cpwm & dir_up_reg & at_term;
  wire        ovf_set  = up_wrap | turn_dn;
  wire [15:0] cnt_inc  = cnt_reg + 16'h0001;
  wire [15:0] cnt_dec  = cnt_reg - 16'h0001;
  reg  [15:0] cnt_next;
  reg         dir_next;

  always @* begin
    cnt_next = cnt_reg;
    dir_next = dir_up_reg;
    if (wr_cnt) begin
      cnt_next = `TPC_CNT_RST;
      dir_next = 1'b1;
    end else if (!cpwm) begin
      dir_next = 1'b1;
      if (tick) begin
        cnt_next = at_term ? `TPC_CNT_RST : cnt_inc;
      end
    end else if (tick) begin
      if (dir_up_reg) begin
        cnt_next = at_term ? cnt_dec : cnt_inc;
        dir_next = ~at_term;
      end else begin
        cnt_next = at_zero ? cnt_inc : cnt_dec;
        dir_next = at_zero;
      end
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      tsc_reg      <= `TPC_TSC_RST;
      ovf_reg      <= 1'b0;
      ovf_arm_reg  <= 1'b0;
      ext_prev_reg <= 1'b0;
      cnt_reg      <= `TPC_CNT_RST;
      dir_up_reg   <= 1'b1;
      mod_reg      <= `TPC_MOD_RST;
      mod_bh_reg   <= 8'h00;
      mod_bl_reg   <= 8'h00;
      mod_hw_reg   <= 1'b0;
      mod_lw_reg   <= 1'b0;
      cnt_buf_reg  <= `TPC_CNT_RST;
      cnt_lat_reg  <= 1'b0;
      cnt_hrd_reg  <= 1'b0;
      cnt_lrd_reg  <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk_in;
      cnt_reg      <= cnt_next;
      dir_up_reg   <= dir_next;
      if (wr_tsc) begin
        tsc_reg <= pwdata[`TPC_TSC_OVIE:`TPC_TSC_CLKS_LO];
      end
      // Overflow flag: a new overflow beats a pending clear and disarms it.
      if (ovf_set) begin
        ovf_reg     <= 1'b1;
        ovf_arm_reg <= 1'b0;
      end else if (wr_tsc && ovf_arm_reg && !pwdata[`TPC_TSC_OVF]) begin
        ovf_reg     <= 1'b0;
        ovf_arm_reg <= 1'b0;
      end else if (rd_tsc && ovf_reg) begin
        ovf_arm_reg <= 1'b1;
      end
      // Modulus byte pairing, cancelled by a timer control write.
      if (wr_tsc) begin
        mod_hw_reg <= 1'b0;
        mod_lw_reg <= 1'b0;
      end else if (wr_modh) begin
        mod_bh_reg <= pwdata[7:0];
        if (mod_lw_reg) begin
          mod_reg    <= {pwdata[7:0], mod_bl_reg};
          mod_lw_reg <= 1'b0;
        end else begin
          mod_hw_reg <= 1'b1;
        end
      end else if (wr_modl) begin
        mod_bl_reg <= pwdata[7:0];
        if (mod_hw_reg) begin
          mod_reg    <= {mod_bh_reg, pwdata[7:0]};
          mod_hw_reg <= 1'b0;
        end else begin
          mod_lw_reg <= 1'b1;
        end
      end
      // Counter read coherency.
      if (wr_cnt) begin
        cnt_lat_reg <= 1'b0;
        cnt_hrd_reg <= 1'b0;
        cnt_lrd_reg <= 1'b0;
      end else if (rd_cnth || rd_cntl) begin
        if (!cnt_lat_reg) begin
          cnt_buf_reg <= cnt_reg;
        end
        if ((rd_cnth && cnt_lrd_reg) || (rd_cntl && cnt_hrd_reg)) begin
          cnt_lat_reg <= 1'b0;
          cnt_hrd_reg <= 1'b0;
          cnt_lrd_reg <= 1'b0;
        end else begin
          cnt_lat_reg <= 1'b1;
          cnt_hrd_reg <= cnt_hrd_reg | rd_cnth;
          cnt_lrd_reg <= cnt_lrd_reg | rd_cntl;
        end
      end
    end
  end

  assign ovf_irq = ovf_reg & ovie;

  wire [15:0] cnt_view = cnt_lat_reg ? cnt_buf_reg : cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Channels.

  wire [`TPC_NUM_CH*8-1:0] ch_rd;

  genvar n;
  generate
    for (n = 0; n < `TPC_NUM_CH; n = n + 1) begin : ch_g
      localparam [3:0] CH_ID = n;
      reg  [4:0]  csc_reg;
      reg         flag_reg;
      reg         arm_reg;
      reg  [15:0] val_reg;
      reg  [15:0] rb_reg;
      reg         rlat_reg;
      reg         rhrd_reg;
      reg         rlrd_reg;
      reg  [7:0]  wbh_reg;
      reg  [7:0]  wbl_reg;
      reg         whw_reg;
      reg         wlw_reg;
      reg         pend_reg;
      reg         pin_reg;
      reg         in_prev_reg;
      reg  [7:0]  rd_byte;

      wire        sel    = ch_hit && (ch_idx == CH_ID);
      wire        wsc    = wr_acc & sel & (ch_sub == `TPC_CH_SUB_SC);
      wire        wvh    = wr_acc & sel & (ch_sub == `TPC_CH_SUB_VH);
      wire        wvl    = wr_acc & sel & (ch_sub == `TPC_CH_SUB_VL);
      wire        rsc    = rd_setup & sel & (ch_sub == `TPC_CH_SUB_SC);
      wire        rvh    = rd_setup & sel & (ch_sub == `TPC_CH_SUB_VH);
      wire        rvl    = rd_setup & sel & (ch_sub == `TPC_CH_SUB_VL);
      wire [1:0]  els    = csc_reg[`TPC_CSC_ELS_HI-2:`TPC_CSC_ELS_LO-2];
      wire [1:0]  mode   = cpwm ? `TPC_MODE_CPWM :
                           csc_reg[`TPC_CSC_MODE_HI-2] ? `TPC_MODE_EPWM :
                           csc_reg[`TPC_CSC_MODE_LO-2] ? `TPC_MODE_CMP : `TPC_MODE_CAP;
      wire        is_cap = (mode == `TPC_MODE_CAP);
      wire        rise   = ch_pin_in[n] & ~in_prev_reg;
      wire        fall   = ~ch_pin_in[n] & in_prev_reg;
      wire        cap_ev = clk_on & is_cap & (((els == `TPC_ELS_01) & rise) | ((els == `TPC_ELS_10) & fall) |
                                              ((els == `TPC_ELS_11) & (rise | fall)));
      wire        match  = tick & ~is_cap & (cnt_reg == val_reg);
      wire        ev     = cap_ev | match;
      wire        pair   = (wvh & wlw_reg) | (wvl & whw_reg);
      wire [15:0] pair_v = wvh ? {pwdata[7:0], wbl_reg} : {wbh_reg, pwdata[7:0]};
      wire        direct = (mode == `TPC_MODE_CMP) | is_cap;
      wire        ld_pnd = pend_reg & (((mode == `TPC_MODE_EPWM) & at_zero) |
                                       ((mode == `TPC_MODE_CPWM) & turn_dn));
      wire        c_off  = (val_reg == `TPC_VAL_RST) | val_reg[15];

      always @(posedge clock) begin
        if (sys_rst) begin
          csc_reg     <= `TPC_CSC_RST;
          flag_reg    <= 1'b0;
          arm_reg     <= 1'b0;
          val_reg     <= `TPC_VAL_RST;
          rb_reg      <= `TPC_VAL_RST;
          rlat_reg    <= 1'b0;
          rhrd_reg    <= 1'b0;
          rlrd_reg    <= 1'b0;
          wbh_reg     <= 8'h00;
          wbl_reg     <= 8'h00;
          whw_reg     <= 1'b0;
          wlw_reg     <= 1'b0;
          pend_reg    <= 1'b0;
          pin_reg     <= 1'b0;
          in_prev_reg <= 1'b0;
        end else begin
          in_prev_reg <= ch_pin_in[n];
          if (wsc) begin
            csc_reg <= pwdata[`TPC_CSC_IE:`TPC_CSC_ELS_LO];
          end
          // Flag: an event in the clearing cycle keeps it set.
          if (ev) begin
            flag_reg <= 1'b1;
            arm_reg  <= 1'b0;
          end else if (wsc && arm_reg && !pwdata[`TPC_CSC_FLAG]) begin
            flag_reg <= 1'b0;
            arm_reg  <= 1'b0;
          end else if (rsc && flag_reg) begin
            arm_reg <= 1'b1;
          end
          // Value register: capture, paired write, deferred PWM load.
          if (cap_ev) begin
            val_reg <= cnt_reg;
          end else if (pair && direct) begin
            val_reg <= pair_v;
          end else if (ld_pnd) begin
            val_reg <= {wbh_reg, wbl_reg};
          end
          if (wsc) begin
            whw_reg  <= 1'b0;
            wlw_reg  <= 1'b0;
            pend_reg <= 1'b0;
          end else if (wvh || wvl) begin
            if (wvh) begin
              wbh_reg <= pwdata[7:0];
            end else begin
              wbl_reg <= pwdata[7:0];
            end
            whw_reg  <= pair ? 1'b0 : (whw_reg | wvh);
            wlw_reg  <= pair ? 1'b0 : (wlw_reg | wvl);
            pend_reg <= pair ? ~direct : pend_reg;
          end else if (ld_pnd) begin
            pend_reg <= 1'b0;
          end
          // Capture read coherency.
          if (wsc) begin
            rlat_reg <= 1'b0;
            rhrd_reg <= 1'b0;
            rlrd_reg <= 1'b0;
          end else if (is_cap && (rvh || rvl)) begin
            if (!rlat_reg) begin
              rb_reg <= val_reg;
            end
            if ((rvh && rlrd_reg) || (rvl && rhrd_reg)) begin
              rlat_reg <= 1'b0;
              rhrd_reg <= 1'b0;
              rlrd_reg <= 1'b0;
            end else begin
              rlat_reg <= 1'b1;
              rhrd_reg <= rhrd_reg | rvh;
              rlrd_reg <= rlrd_reg | rvl;
            end
          end
          // Pin action.
          if (tick && (els != `TPC_ELS_OFF)) begin
            case (mode)
              `TPC_MODE_CMP: begin
                if (match) begin
                  pin_reg <= (els == `TPC_ELS_01) ? ~pin_reg : els[0];
                end
              end
              `TPC_MODE_EPWM: begin
                if (match) begin
                  pin_reg <= els[0];
                end
                if (up_wrap) begin
                  pin_reg <= ~els[0];
                end
              end
              `TPC_MODE_CPWM: begin
                if (c_off) begin
                  pin_reg <= els[0];
                end else if (match) begin
                  pin_reg <= dir_up_reg ? els[0] : ~els[0];
                end
              end
              default: begin
                pin_reg <= pin_reg;
              end
            endcase
          end
        end
      end

      always @* begin
        case (ch_sub)
          `TPC_CH_SUB_SC: rd_byte = {flag_reg, csc_reg, 2'b00};
          `TPC_CH_SUB_VH: rd_byte = (is_cap && rlat_reg) ? rb_reg[15:8] : val_reg[15:8];
          `TPC_CH_SUB_VL: rd_byte = (is_cap && rlat_reg) ? rb_reg[7:0] : val_reg[7:0];
          default:        rd_byte = 8'h00;
        endcase
      end

      assign ch_rd[n*8 +: 8] = sel ? rd_byte : 8'h00;
      assign ch_pin_out[n]   = pin_reg;
      assign ch_pin_oe[n]    = (els != `TPC_ELS_OFF) && !is_cap;
      assign ch_irq[n]       = flag_reg & csc_reg[`TPC_CSC_IE-2];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle.

  reg  [7:0]  ch_rd_any;
  reg  [7:0]  top_rd;
  integer     i;

  always @* begin
    ch_rd_any = 8'h00;
    for (i = 0; i < `TPC_NUM_CH; i = i + 1) begin
      ch_rd_any = ch_rd_any | ch_rd[i*8 +: 8];
    end
    case (paddr)
      `TPC_ADDR_TSC:  top_rd = {ovf_reg, tsc_reg, 3'b000};
      `TPC_ADDR_CNTH: top_rd = cnt_view[15:8];
      `TPC_ADDR_CNTL: top_rd = cnt_view[7:0];
      `TPC_ADDR_MODH: top_rd = mod_reg[15:8];
      `TPC_ADDR_MODL: top_rd = mod_reg[7:0];
      default:        top_rd = 8'h00;
    endcase
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {24'h000000, (top_rd | ch_rd_any)};
    end
  end

endmodule // tpc_timer
`default_nettype wire
